// *** bench/pgc_power_stage.sv ***
// Power-stage model: tallies gate-drive time per pin and shoot-through
`timescale 1ns/1ps
module pgc_power_stage (
  input  wire logic            aclk,
  input  wire logic            clr,
  input  wire logic [5:0]      pwm_in,
  input  wire logic [2:0]      pair_on,
  output logic      [5:0][7:0] hi_cnt,
  output logic      [7:0]      overlap
);
  logic [2:0] both_on;

  // A leg conducts while its pin is high; clr opens a new window
  always_ff @(posedge aclk) begin
    for (int i = 0; i < 6; i++) begin
      hi_cnt[i] <= clr ? 8'h00 : hi_cnt[i] + 8'(pwm_in[i]);
    end
  end

  // Both legs of a paired bridge on together would short the supply
  assign both_on = pair_on & {pwm_in[5] & pwm_in[4], pwm_in[3] & pwm_in[2], pwm_in[1] & pwm_in[0]};
  always_ff @(posedge aclk) begin
    overlap <= clr ? 8'h00 : overlap + 8'(|both_on);
  end
endmodule

// *** bench/pwm_generator_control_tb_top.sv ***
// Testbench for the generator control block: bus, counting modes, update timing
`timescale 1ns/1ps
module pwm_generator_control_tb_top;
  import pgc_pkg::*;
  logic            aclk = 1'b0;
  logic            aresetn = 1'b0;
  logic [11:0]     awaddr = 12'h000;
  logic [11:0]     araddr = 12'h000;
  logic [31:0]     wdata = 32'h0000_0000;
  logic            awvalid = 1'b0;
  logic            wvalid = 1'b0;
  logic            bready = 1'b0;
  logic            arvalid = 1'b0;
  logic            rready = 1'b0;
  logic            dbg_halt = 1'b0;
  logic            clr = 1'b0;
  logic [2:0]      pair_on = 3'b000;
  logic            awready, wready, bvalid, arready, rvalid;
  logic [1:0]      bresp, rresp, rsp;
  logic [31:0]     rdata, rdv;
  logic [5:0]      pwm_out;
  logic [5:0][7:0] hi_cnt;
  logic [7:0]      overlap;
  int              fails = 0;
  int              checks_done = 0;

  pgc_top #(.CW(CNT_W)) i_pgc_top (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'b000),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hf),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arprot(3'b000), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .dbg_halt(dbg_halt), .pwm_out(pwm_out)
  );

  pgc_power_stage i_pgc_power_stage (
    .aclk(aclk), .clr(clr), .pwm_in(pwm_out), .pair_on(pair_on),
    .hi_cnt(hi_cnt), .overlap(overlap)
  );

  // 20 MHz system clock
  always #25 aclk = ~aclk;

  task automatic give_verdict();
    if (fails == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic time_out();
    fails++;
    give_verdict();
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Pin high-time over one window for the A and B pins of unit u
  task automatic chk_cnt(input int u, input logic [7:0] ea, input logic [7:0] eb);
    chk({24'h00_0000, hi_cnt[2*u]}, {24'h00_0000, ea});
    chk({24'h00_0000, hi_cnt[2*u+1]}, {24'h00_0000, eb});
  endtask

  function automatic logic [11:0] ua(input int u, input logic [5:0] sub);
    return OFF_CTL0 * 12'(u + 1) + {6'h00, sub};
  endfunction

  // Write: address and data offered together, each dropped once taken
  task automatic bus_wr(input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 40);
    rsp = bresp;
    bready <= 1'b0;
    if (n >= 40) time_out();
  endtask

  // Read: data and response are taken at the edge that sees rvalid
  task automatic bus_rd(input logic [11:0] a);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 40);
    rdv = rdata;
    rsp = rresp;
    rready <= 1'b0;
    if (n >= 40) time_out();
  endtask

  // Forty cycles is a whole number of periods of every pattern used here
  task automatic measure();
    @(posedge aclk);
    clr <= 1'b1;
    @(posedge aclk);
    clr <= 1'b0;
    repeat (40) @(posedge aclk);
    #1;
  endtask

  task automatic s_map();
    for (int u = 0; u < NUM_UNITS; u++) begin
      bus_rd(ua(u, SUB_CTL));
      chk(rdv, 32'h0000_0000);
    end
    bus_rd(12'h3f0);
    chk({30'h0000_0000, rsp}, {30'h0000_0000, RESP_SLVERR});
    bus_wr(12'h3f0, 32'h0000_00ff);
    chk({30'h0000_0000, rsp}, {30'h0000_0000, RESP_SLVERR});
    // Count register is read-only: a write answers OKAY and changes nothing
    bus_wr(ua(0, SUB_COUNT), 32'h0000_0007);
    chk({30'h0000_0000, rsp}, {30'h0000_0000, RESP_OK});
    bus_rd(ua(0, SUB_COUNT));
    chk(rdv, 32'h0000_0000);
    bus_wr(OFF_CTL2, 32'hffff_ff3e);
    chk({30'h0000_0000, rsp}, {30'h0000_0000, RESP_OK});
    bus_rd(OFF_CTL2);
    chk(rdv, 32'h0000_003e);
    bus_rd(OFF_CTL1);
    chk(rdv, 32'h0000_0000);
    bus_wr(OFF_CTL2, 32'h0000_0000);
  endtask

  // Unit 0 down, unit 1 up/down, unit 2 down with a shorter load
  task automatic s_modes();
    for (int u = 0; u < NUM_UNITS; u++) begin
      bus_wr(ua(u, SUB_LOAD), u == 2 ? 32'h0000_0003 : 32'h0000_0004);
      bus_wr(ua(u, SUB_CMPA), u == 2 ? 32'h0000_0001 : 32'h0000_0002);
      bus_wr(ua(u, SUB_CMPB), 32'h0000_0003);
    end
    bus_wr(OFF_CTL0, 32'h0000_0001);
    bus_wr(OFF_CTL1, 32'h0000_0003);
    bus_wr(OFF_CTL2, 32'h0000_0001);
    repeat (10) @(posedge aclk);
    measure();
    chk_cnt(0, 8'h10, 8'h18);
    chk_cnt(1, 8'h0f, 8'h19);
    chk_cnt(2, 8'h0a, 8'h1e);
  endtask

  task automatic s_disable();
    bus_wr(OFF_CTL1, 32'h0000_0000);
    measure();
    chk_cnt(1, 8'h00, 8'h00);
    chk_cnt(0, 8'h10, 8'h18);
    bus_rd(ua(1, SUB_COUNT));
    chk(rdv, 32'h0000_0000);
  endtask

  // Unit 2 updates at the next zero; unit 0 waits for the sync request
  task automatic s_update();
    bus_wr(ua(2, SUB_CMPA), 32'h0000_0002);
    bus_wr(OFF_CTL0, 32'h0000_0039);
    bus_wr(ua(0, SUB_CMPA), 32'h0000_0005);
    repeat (20) @(posedge aclk);
    measure();
    chk_cnt(0, 8'h10, 8'h18);
    chk_cnt(2, 8'h14, 8'h1e);
    bus_wr(OFF_GLOBAL, 32'h0000_0001);
    repeat (10) @(posedge aclk);
    measure();
    chk_cnt(0, 8'h28, 8'h18);
  endtask

  // Unit 0 stops at zero under halt, unit 2 ignores the halt
  task automatic s_debug();
    bus_wr(OFF_CTL0, 32'h0000_0001);
    bus_wr(OFF_CTL2, 32'h0000_0005);
    @(posedge aclk);
    dbg_halt <= 1'b1;
    repeat (10) @(posedge aclk);
    measure();
    chk_cnt(0, 8'h28, 8'h28);
    chk_cnt(2, 8'h14, 8'h1e);
    @(posedge aclk);
    dbg_halt <= 1'b0;
    repeat (10) @(posedge aclk);
    measure();
    chk_cnt(0, 8'h28, 8'h18);
  endtask

  // Unit 1 paired, delay 1: each pin loses two cycles at the raw-wave edge that turns it on
  task automatic s_paired();
    bus_wr(ua(1, SUB_LOAD), 32'h0000_0009);
    bus_wr(ua(1, SUB_CMPA), 32'h0000_0005);
    bus_wr(ua(1, SUB_DBAND), 32'h0001_0001);
    bus_wr(OFF_CTL1, 32'h0000_0001);
    pair_on <= 3'b010;
    repeat (20) @(posedge aclk);
    measure();
    chk_cnt(1, 8'h0c, 8'h0c);
    chk({24'h00_0000, overlap}, 32'h0000_0000);
  endtask

  // Reset for four cycles, then the scenarios in order
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    s_map();
    s_modes();
    s_disable();
    s_update();
    s_debug();
    s_paired();
    give_verdict();
  end
endmodule

// *** rtl/pgc_pkg.sv ***
// Package: register map, field positions and reset values of the generator control block
package pgc_pkg;
  localparam int          NUM_UNITS  = 3;
  localparam int          CNT_W      = 16;
  localparam int          DB_W       = 8;
  localparam int          CTL_W      = 6;
  // Byte addresses
  localparam logic [11:0] OFF_GLOBAL = 12'h000;
  localparam logic [11:0] OFF_CTL0   = 12'h040;
  localparam logic [11:0] OFF_CTL1   = 12'h080;
  localparam logic [11:0] OFF_CTL2   = 12'h0c0;
  // Offsets inside one unit window
  localparam logic [5:0]  SUB_CTL    = 6'h00;
  localparam logic [5:0]  SUB_LOAD   = 6'h10;
  localparam logic [5:0]  SUB_CMPA   = 6'h14;
  localparam logic [5:0]  SUB_CMPB   = 6'h18;
  localparam logic [5:0]  SUB_COUNT  = 6'h1c;
  localparam logic [5:0]  SUB_DBAND  = 6'h28;
  // Control register fields
  localparam int          CTL_EN     = 0;
  localparam int          CTL_MODE   = 1;
  localparam int          CTL_DEBUG  = 2;
  localparam int          CTL_LDUPD  = 3;
  localparam int          CTL_CAUPD  = 4;
  localparam int          CTL_CBUPD  = 5;
  // Dead-band register fields
  localparam int          DB_PAIR    = 16;
  // Reset values
  localparam logic [CTL_W-1:0] CTL_RST = 6'h00;
  localparam logic [CNT_W-1:0] VAL_RST = 16'h0000;
  localparam logic [DB_W-1:0]  DB_RST  = 8'h00;
  // Bus responses
  localparam logic [1:0]  RESP_OK    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
endpackage

// *** rtl/pgc_top.sv ***
// Generator control top: AXI4-Lite register slave and three generator units
//
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/1ps
// How it works
// - Each unit has its own control register; unit 2 at 0x0C0.
// - Unit 0 drives output signals 0 and 1.
// - Unit 1 drives signals 2 and 3, unit 2 drives 4 and 5.
// - Independent mode: both outputs compare against the one shared counter.
// - Paired mode: complementary outputs with dead-band delay between edges.
// - Mode 0: count down from load to zero, reload, repeat.
// - Mode 1: count up to load, down to zero, repeat.
// - Enable 0: unit frozen, counter zero, outputs low.
// - Enable 1: unit counts and produces its outputs.
module pgc_top
  import pgc_pkg::*;
#(
  parameter int CW = CNT_W
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [11:0] awaddr,
  input  wire logic [2:0]  awprot,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [11:0] araddr,
  input  wire logic [2:0]  arprot,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire logic        dbg_halt,
  output logic [5:0]       pwm_out
);
  typedef struct packed {
    logic                            aw_ok;
    logic [11:0]                     awaddr;
    logic                            w_ok;
    logic [31:0]                     wdata;
    logic [3:0]                      wstrb;
    logic                            awready;
    logic                            wready;
    logic                            bvalid;
    logic [1:0]                      bresp;
    logic                            arready;
    logic                            rvalid;
    logic [31:0]                     rdata;
    logic [1:0]                      rresp;
    logic [NUM_UNITS-1:0][CTL_W-1:0] ctl;
    logic [NUM_UNITS-1:0][CW-1:0]    load;
    logic [NUM_UNITS-1:0][CW-1:0]    cmpa;
    logic [NUM_UNITS-1:0][CW-1:0]    cmpb;
    logic [NUM_UNITS-1:0][DB_W-1:0]  db_dly;
    logic [NUM_UNITS-1:0]            db_pair;
    logic [NUM_UNITS-1:0][2:0]       wr_pulse;
    logic [NUM_UNITS-1:0]            sync;
  } pgc_top_st_t;

  pgc_top_st_t                  s;
  pgc_top_st_t                  next_s;
  logic [NUM_UNITS-1:0][CW-1:0] ucnt;
  logic [NUM_UNITS-1:0]         ua;
  logic [NUM_UNITS-1:0]         ub;
  logic [32:0]                  rd;
  logic [32:0]                  wr_cur;
  logic [31:0]                  m;
  logic [1:0]                   u;
  logic                         wr_fire;

  assign awready = s.awready;
  assign wready  = s.wready;
  assign bvalid  = s.bvalid;
  assign bresp   = s.bresp;
  assign arready = s.arready;
  assign rvalid  = s.rvalid;
  assign rdata   = s.rdata;
  assign rresp   = s.rresp;

  // Byte-lane merge of a write into the current register contents
  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
                                        input logic [3:0] st);
    for (int b = 0; b < 4; b++) begin
      if (st[b]) begin
        o[8*b +: 8] = d[8*b +: 8];
      end
    end
    return o;
  endfunction

  // Register read-back; top bit flags a mapped address
  function automatic logic [32:0] reg_rd(input logic [11:0] a);
    logic [1:0]  ui;
    logic [31:0] v;
    logic        hit;
    ui  = a[7:6] - 2'd1;
    v   = 32'h0000_0000;
    hit = 1'b0;
    if (a == OFF_GLOBAL) begin
      hit = 1'b1; // Sync requests are pulses and read as zero
    end else if (a[11:8] == 4'h0 && a[7:6] != 2'd0) begin
      hit = 1'b1;
      case (a[5:0])
        SUB_CTL:   v[CTL_W-1:0] = s.ctl[ui];
        SUB_LOAD:  v[CW-1:0] = s.load[ui];
        SUB_CMPA:  v[CW-1:0] = s.cmpa[ui];
        SUB_CMPB:  v[CW-1:0] = s.cmpb[ui];
        SUB_COUNT: v[CW-1:0] = ucnt[ui];
        SUB_DBAND: begin
          v[DB_W-1:0] = s.db_dly[ui];
          v[DB_PAIR] = s.db_pair[ui];
        end
        default:   hit = 1'b0;
      endcase
    end
    return {hit, v};
  endfunction

  // Bus handshakes and register writes
  always_comb begin
    next_s = s;
    next_s.wr_pulse = '0;
    next_s.sync = '0;
    rd = reg_rd(araddr);
    wr_cur = reg_rd(s.awaddr);
    m = merge(wr_cur[31:0], s.wdata, s.wstrb);
    u = s.awaddr[7:6] - 2'd1;
    wr_fire = s.aw_ok && s.w_ok && !s.bvalid;
    if (awvalid && s.awready) begin
      next_s.aw_ok = 1'b1;
      next_s.awaddr = awaddr;
    end
    if (wvalid && s.wready) begin
      next_s.w_ok = 1'b1;
      next_s.wdata = wdata;
      next_s.wstrb = wstrb;
    end
    if (s.bvalid && bready) begin
      next_s.bvalid = 1'b0;
    end
    if (wr_fire) begin
      next_s.aw_ok = 1'b0;
      next_s.w_ok = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = wr_cur[32] ? RESP_OK : RESP_SLVERR;
      if (s.awaddr == OFF_GLOBAL) begin
        next_s.sync = m[NUM_UNITS-1:0];
      end else if (wr_cur[32]) begin
        // Only the addressed unit's fields change
        case (s.awaddr[5:0])
          SUB_CTL: next_s.ctl[u] = m[CTL_W-1:0];
          SUB_LOAD: begin
            next_s.load[u] = m[CW-1:0];
            next_s.wr_pulse[u][0] = 1'b1;
          end
          SUB_CMPA: begin
            next_s.cmpa[u] = m[CW-1:0];
            next_s.wr_pulse[u][1] = 1'b1;
          end
          SUB_CMPB: begin
            next_s.cmpb[u] = m[CW-1:0];
            next_s.wr_pulse[u][2] = 1'b1;
          end
          SUB_DBAND: begin
            next_s.db_dly[u] = m[DB_W-1:0];
            next_s.db_pair[u] = m[DB_PAIR];
          end
          default: next_s.bresp = RESP_OK; // Count register ignores writes
        endcase
      end
    end
    // Ready drops while a word is held so a second one cannot overwrite it
    next_s.awready = !next_s.aw_ok && !next_s.bvalid;
    next_s.wready = !next_s.w_ok && !next_s.bvalid;
    if (arvalid && s.arready) begin
      next_s.rvalid = 1'b1;
      next_s.rdata = rd[31:0];
      next_s.rresp = rd[32] ? RESP_OK : RESP_SLVERR;
    end else if (s.rvalid && rready) begin
      next_s.rvalid = 1'b0;
    end
    next_s.arready = !next_s.rvalid;
  end

  // State register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
      s.ctl <= {NUM_UNITS{CTL_RST}};
      s.load <= {NUM_UNITS{VAL_RST}};
      s.cmpa <= {NUM_UNITS{VAL_RST}};
      s.cmpb <= {NUM_UNITS{VAL_RST}};
      s.db_dly <= {NUM_UNITS{DB_RST}};
    end else begin
      s <= next_s;
    end
  end

  // One unit per pin pair; unit n owns pins 2n and 2n+1
  for (genvar i = 0; i < NUM_UNITS; i++) begin : g_unit
    pgc_unit #(
      .CW (CW)
    ) u_unit (
      .aclk     (aclk),
      .aresetn  (aresetn),
      .ctl      (s.ctl[i]),
      .load_sh  (s.load[i]),
      .cmpa_sh  (s.cmpa[i]),
      .cmpb_sh  (s.cmpb[i]),
      .wr_pulse (s.wr_pulse[i]),
      .db_dly   (s.db_dly[i]),
      .db_pair  (s.db_pair[i]),
      .sync_req (s.sync[i]),
      .dbg_halt (dbg_halt),
      .cnt      (ucnt[i]),
      .out_a    (ua[i]),
      .out_b    (ub[i])
    );
    assign pwm_out[2*i]   = ua[i];
    assign pwm_out[2*i+1] = ub[i];
  end

  sequence seq_u0_off;
    !s.ctl[0][CTL_EN] [*2];
  endsequence
  sequence seq_u1_off;
    !s.ctl[1][CTL_EN] [*2];
  endsequence
  sequence seq_u2_off;
    !s.ctl[2][CTL_EN] [*2];
  endsequence

  chk_unit_isolation: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_fire && s.awaddr == OFF_CTL2 |=> $stable(s.ctl[0]) && $stable(s.ctl[1])
    && s.ctl[2] == $past(m[CTL_W-1:0]))
    else $error("unit 2 control write leaked or was lost");
  chk_pins_unit0: assert property (@(posedge aclk) disable iff (!aresetn)
    seq_u0_off |-> pwm_out[1:0] == 2'b00 && ucnt[0] == '0)
    else $error("unit 0 pins active while disabled");
  chk_pins_unit1: assert property (@(posedge aclk) disable iff (!aresetn)
    seq_u1_off |-> pwm_out[3:2] == 2'b00)
    else $error("unit 1 pins active while disabled");
  chk_pins_unit2: assert property (@(posedge aclk) disable iff (!aresetn)
    seq_u2_off |-> pwm_out[5:4] == 2'b00)
    else $error("unit 2 pins active while disabled");
endmodule

// *** rtl/pgc_unit.sv ***
// One generator unit: shared counter, update shadows, output pair with dead-band
`timescale 1ns/1ps
module pgc_unit
  import pgc_pkg::*;
#(
  parameter int CW = CNT_W
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [CTL_W-1:0]  ctl,
  input  wire logic [CW-1:0]     load_sh,
  input  wire logic [CW-1:0]     cmpa_sh,
  input  wire logic [CW-1:0]     cmpb_sh,
  input  wire logic [2:0]        wr_pulse,
  input  wire logic [DB_W-1:0]   db_dly,
  input  wire logic              db_pair,
  input  wire logic              sync_req,
  input  wire logic              dbg_halt,
  output logic      [CW-1:0]     cnt,
  output logic                   out_a,
  output logic                   out_b
);
  typedef struct packed {
    logic [CW-1:0]   cnt;
    logic            up;
    logic            halted;
    logic [CW-1:0]   load_act;
    logic [CW-1:0]   cmpa_act;
    logic [CW-1:0]   cmpb_act;
    logic [2:0]      dirty;
    logic            armed;
    logic            raw_prev;
    logic [DB_W-1:0] db_cnt;
    logic            out_a;
    logic            out_b;
  } pgc_unit_st_t;

  pgc_unit_st_t s;
  pgc_unit_st_t next_s;
  logic         hold;
  logic         step;
  logic         zero;
  logic [2:0]   take;
  logic [2:0]   upd;
  logic [CW-1:0] nl;
  logic         raw_a;
  logic         raw_b;
  logic         gate;

  assign cnt   = s.cnt;
  assign out_a = s.out_a;
  assign out_b = s.out_b;

  // Counter, shadow transfer, debug halt and output shaping
  always_comb begin
    next_s = s;
    hold = dbg_halt && !ctl[CTL_DEBUG] && (s.halted || s.cnt == '0);
    step = ctl[CTL_EN] && !hold;
    zero = step && (s.cnt == '0);
    upd  = {ctl[CTL_CBUPD], ctl[CTL_CAUPD], ctl[CTL_LDUPD]};
    take = {3{zero}} & s.dirty & (~upd | {3{s.armed}});
    nl   = take[0] ? load_sh : s.load_act;
    raw_a = s.cnt < s.cmpa_act;
    raw_b = s.cnt < s.cmpb_act;
    gate  = (raw_a == s.raw_prev) && (s.db_cnt >= db_dly);
    next_s.halted = ctl[CTL_EN] && hold;
    // A write landing on the transfer cycle stays pending: set wins
    next_s.dirty = wr_pulse | (s.dirty & ~take);
    next_s.armed = sync_req | (s.armed & ~zero);
    next_s.load_act = nl;
    if (take[1]) begin
      next_s.cmpa_act = cmpa_sh;
    end
    if (take[2]) begin
      next_s.cmpb_act = cmpb_sh;
    end
    if (!ctl[CTL_EN]) begin
      // Disabled unit stands frozen at zero with both pins low
      next_s.cnt = '0;
      next_s.up = 1'b1;
      next_s.out_a = 1'b0;
      next_s.out_b = 1'b0;
      next_s.db_cnt = '0;
      next_s.raw_prev = 1'b0;
    end else begin
      if (step) begin
        if (!ctl[CTL_MODE]) begin
          next_s.up = 1'b0;
          next_s.cnt = (s.cnt == '0) ? nl : s.cnt - 1'b1;
        end else if (s.cnt == '0) begin
          next_s.up = 1'b1;
          next_s.cnt = (nl != '0) ? {{(CW-1){1'b0}}, 1'b1} : '0;
        end else if (s.up && s.cnt < nl) begin
          next_s.cnt = s.cnt + 1'b1;
        end else begin
          next_s.up = 1'b0;
          next_s.cnt = s.cnt - 1'b1;
        end
      end
      if (!db_pair) begin
        next_s.out_a = raw_a;
        next_s.out_b = raw_b;
      end else begin
        // Both pins stay low until the edge has aged by the delay
        next_s.raw_prev = raw_a;
        if (raw_a != s.raw_prev) begin
          next_s.db_cnt = '0;
        end else if (s.db_cnt != {DB_W{1'b1}}) begin
          next_s.db_cnt = s.db_cnt + 1'b1;
        end
        next_s.out_a = raw_a && gate;
        next_s.out_b = !raw_a && gate;
      end
    end
  end

  // State register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '{cnt: '0, up: 1'b1, halted: 1'b0, load_act: '0, cmpa_act: '0, cmpb_act: '0,
             dirty: 3'h0, armed: 1'b0, raw_prev: 1'b0, db_cnt: '0, out_a: 1'b0,
             out_b: 1'b0};
    end else begin
      s <= next_s;
    end
  end

  sequence seq_halt_at_zero;
    ctl[CTL_EN] && dbg_halt && !ctl[CTL_DEBUG] && s.cnt == '0;
  endsequence

  chk_down_step: assert property (@(posedge aclk) disable iff (!aresetn)
    step && !ctl[CTL_MODE] && s.cnt != '0 |=> s.cnt == $past(s.cnt) - 1'b1)
    else $error("down count did not decrement");
  chk_down_reload: assert property (@(posedge aclk) disable iff (!aresetn)
    step && !ctl[CTL_MODE] && s.cnt == '0 |=> s.cnt == s.load_act)
    else $error("down count did not reload at zero");
  chk_updown_rise: assert property (@(posedge aclk) disable iff (!aresetn)
    step && ctl[CTL_MODE] && s.up && s.cnt != '0 && s.cnt < s.load_act
    |=> s.cnt == $past(s.cnt) + 1'b1)
    else $error("up/down count did not increment");
  chk_disable_idle: assert property (@(posedge aclk) disable iff (!aresetn)
    !ctl[CTL_EN] |=> s.cnt == '0 && !s.out_a && !s.out_b)
    else $error("disabled unit still active");
  chk_enabled_runs: assert property (@(posedge aclk) disable iff (!aresetn)
    ctl[CTL_EN] && !dbg_halt && !s.halted && s.load_act != '0 && load_sh != '0
    |=> s.cnt != $past(s.cnt))
    else $error("enabled unit did not count");
  chk_indep_out: assert property (@(posedge aclk) disable iff (!aresetn)
    ctl[CTL_EN] && !db_pair |=> s.out_a == ($past(s.cnt) < $past(s.cmpa_act)))
    else $error("independent output A wrong");
  chk_pair_exclusive: assert property (@(posedge aclk) disable iff (!aresetn)
    ctl[CTL_EN] && db_pair |=> !(s.out_a && s.out_b))
    else $error("paired outputs overlap");
  chk_load_update: assert property (@(posedge aclk) disable iff (!aresetn)
    zero && s.dirty[0] && !ctl[CTL_LDUPD] |=> s.load_act == $past(load_sh))
    else $error("load value not taken at zero");
  chk_debug_stop: assert property (@(posedge aclk) disable iff (!aresetn)
    seq_halt_at_zero |=> $stable(s.cnt))
    else $error("counter ran during debug halt");
endmodule
